//--- design/intc_ack.sv
// interrupt prioritiser with per-level and software acknowledge reads
// assumes an axi4-lite master on clk_i; requests and events come from pins
//
// Implementation choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - global level ack returns best unmasked vector of that level across controllers
// - global space holds no software ack register; that address errors
// - software ack returns best unmasked vector within one controller
// - lower force register reads back the value last written
// - controller 0 sources 24 to 26 clear by writing one after reading one
// - source control registers reset to level zero, meaning disabled
// - watchdog request level comes from source slot 8
// - watchdog timeout only raises an interrupt request, never a reset
// - acknowledge is a read of dedicated addresses encoding the level
module intc_ack (
	input  wire logic                       clk_i,
	input  wire logic                       rst_n_i,
	input  wire logic [intc_pkg::ADDR_W-1:0] s_axi_awaddr_i,
	input  wire logic                       s_axi_awvalid_i,
	output var  logic                       s_axi_awready_o,
	input  wire logic [31:0]                s_axi_wdata_i,
	input  wire logic [3:0]                 s_axi_wstrb_i,
	input  wire logic                       s_axi_wvalid_i,
	output var  logic                       s_axi_wready_o,
	output var  logic [1:0]                 s_axi_bresp_o,
	output var  logic                       s_axi_bvalid_o,
	input  wire logic                       s_axi_bready_i,
	input  wire logic [intc_pkg::ADDR_W-1:0] s_axi_araddr_i,
	input  wire logic                       s_axi_arvalid_i,
	output var  logic                       s_axi_arready_o,
	output var  logic [31:0]                s_axi_rdata_o,
	output var  logic [1:0]                 s_axi_rresp_o,
	output var  logic                       s_axi_rvalid_o,
	input  wire logic                       s_axi_rready_i,
	input  wire logic [intc_pkg::NUM_REQ-1:0] hw_req_i,
	input  wire logic                       wdog_timeout_i,
	input  wire logic [intc_pkg::CAN_COUNT-1:0] can_event_i,
	output var  logic [2:0]                 ipl_o,
	output var  logic                       irq_o
);
	import intc_pkg::*;

	// ==================================================
	// reset release and input synchronisers
	logic rst_s1, rst_n;
	logic [NUM_REQ-1:0] req_s1, req_s2;
	logic wd_s1, wd_s2, wd_s3;
	logic [CAN_COUNT-1:0] can_s1, can_s2;

	// reset asserts at once, releases after two edges
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_s1 <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n  <= rst_s1;
		end
	end

	// pins are asynchronous; second stages feed logic, plus a third watchdog stage for its edge
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			req_s1 <= '0;
			req_s2 <= '0;
			wd_s1  <= 1'b0;
			wd_s2  <= 1'b0;
			wd_s3  <= 1'b0;
			can_s1 <= '0;
			can_s2 <= '0;
		end else begin
			req_s1 <= hw_req_i;
			req_s2 <= req_s1;
			wd_s1  <= wdog_timeout_i;
			wd_s2  <= wd_s1;
			wd_s3  <= wd_s2;
			can_s1 <= can_event_i;
			can_s2 <= can_s1;
		end
	end

	// ==================================================
	// state
	logic [31:0] mask [NUM_CTRL];
	logic [31:0] force_low_reg [NUM_CTRL];
	logic [5:0]  source_level_priority_reg [NUM_CTRL][NUM_SRC];
	logic [CAN_COUNT-1:0] can_flag, can_armed;
	logic wdog_pend;
	logic [NUM_EVT-1:0] status, enable;
	logic aw_held, w_held;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;

	logic [31:0] next_mask [NUM_CTRL];
	logic [31:0] next_force_low_reg [NUM_CTRL];
	logic [5:0]  next_source_level_priority_reg [NUM_CTRL][NUM_SRC];
	logic [CAN_COUNT-1:0] next_can_flag, next_can_armed;
	logic next_wdog_pend;
	logic [NUM_EVT-1:0] next_status, next_enable;
	logic next_aw_held, next_w_held;
	logic [ADDR_W-1:0] next_aw_addr;
	logic [31:0] next_w_data;
	logic [3:0]  next_w_strb;
	logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
	logic [1:0]  next_bresp, next_rresp;
	logic [31:0] next_rdata;
	logic [2:0]  next_ipl;
	logic next_irq;

	// ==================================================
	// prioritisation
	logic [31:0] pending [NUM_CTRL];
	logic [31:0] active [NUM_CTRL];
	logic        lvl_hit [NUM_CTRL][8];
	logic [2:0]  lvl_prio [NUM_CTRL][8];
	logic [7:0]  lvl_vec [NUM_CTRL][8];
	logic [7:0]  sw_vec [NUM_CTRL];
	logic        sw_hit [NUM_CTRL];
	logic        g_hit [8];
	logic [2:0]  g_prio [8];
	logic [7:0]  g_vec [8];
	logic [2:0]  top_lvl;
	logic [7:0]  wdog_vec;

	// the watchdog asks for service through source 8 and status bit ST_WDOG; nothing here can reset
	always_comb begin
		wdog_vec = 8'(VEC_BASE + WDOG_SRC);
		top_lvl = 3'h0;
		for (int c = 0; c < NUM_CTRL; c++) begin
			pending[c] = req_s2[c*NUM_SRC +: NUM_SRC] | force_low_reg[c];
			if (c == 0) begin
				pending[c][WDOG_SRC] = pending[c][WDOG_SRC] | wdog_pend;
				pending[c][CAN_FIRST +: CAN_COUNT] = can_flag;
			end
			active[c] = pending[c] & ~mask[c];
			sw_hit[c] = 1'b0;
			sw_vec[c] = SPURIOUS_VEC;
			for (int l = 0; l < 8; l++) begin
				lvl_hit[c][l] = 1'b0;
				lvl_prio[c][l] = 3'h0;
				lvl_vec[c][l] = SPURIOUS_VEC;
				for (int s = 0; s < NUM_SRC; s++) begin
					// level zero is the disabled reset state
					if (l != 0 && active[c][s] &&
					    source_level_priority_reg[c][s][5:3] == 3'(l) &&
					    (!lvl_hit[c][l] ||
					     source_level_priority_reg[c][s][2:0] > lvl_prio[c][l])) begin
						lvl_hit[c][l] = 1'b1;
						lvl_prio[c][l] = source_level_priority_reg[c][s][2:0];
						lvl_vec[c][l] = 8'(VEC_BASE + c*NUM_SRC + s);
					end
				end
				// higher level overrides, so the last hit wins
				if (lvl_hit[c][l]) begin
					sw_hit[c] = 1'b1;
					sw_vec[c] = lvl_vec[c][l];
					if (3'(l) > top_lvl) top_lvl = 3'(l);
				end
			end
		end
		// ties between controllers go to the lower one; unique settings avoid them
		for (int l = 0; l < 8; l++) begin
			g_hit[l] = 1'b0;
			g_prio[l] = 3'h0;
			g_vec[l] = SPURIOUS_VEC;
			for (int c = 0; c < NUM_CTRL; c++) begin
				if (lvl_hit[c][l] && (!g_hit[l] || lvl_prio[c][l] > g_prio[l])) begin
					g_hit[l] = 1'b1;
					g_prio[l] = lvl_prio[c][l];
					g_vec[l] = lvl_vec[c][l];
				end
			end
		end
	end

	// ==================================================
	// register bus: decode, side effects, next state
	logic [3:0] rblk, wblk;
	logic [7:0] rofs, wofs;
	logic       rc, wc;
	logic       ar_hs, do_wr;
	logic [4:0] slot_idx;
	logic [2:0] lvl;
	logic       spur_set;

	always_comb begin
		for (int c = 0; c < NUM_CTRL; c++) begin
			next_mask[c] = mask[c];
			next_force_low_reg[c] = force_low_reg[c];
			for (int s = 0; s < NUM_SRC; s++)
				next_source_level_priority_reg[c][s] = source_level_priority_reg[c][s];
		end
		next_can_flag = can_flag | can_s2;
		next_can_armed = can_armed;
		next_wdog_pend = wdog_pend;
		next_status = status;
		next_enable = enable;
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held = w_held;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = s_axi_bvalid_o;
		next_bresp = s_axi_bresp_o;
		next_rvalid = s_axi_rvalid_o;
		next_rdata = s_axi_rdata_o;
		next_rresp = s_axi_rresp_o;
		rblk = s_axi_araddr_i[11:8];
		rofs = s_axi_araddr_i[7:0];
		rc = s_axi_araddr_i[8];
		wblk = aw_addr[11:8];
		wofs = aw_addr[7:0];
		wc = aw_addr[8];
		slot_idx = 5'h0;
		lvl = 3'h0;
		spur_set = 1'b0;
		ar_hs = s_axi_arvalid_i && s_axi_arready_o;
		do_wr = aw_held && w_held && !s_axi_bvalid_o;

		// address and data are taken in either order and held
		if (s_axi_awvalid_i && s_axi_awready_o) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && s_axi_wready_o) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata_i;
			next_w_strb = s_axi_wstrb_i;
		end
		if (s_axi_bvalid_o && s_axi_bready_i) next_bvalid = 1'b0;
		if (s_axi_rvalid_o && s_axi_rready_i) next_rvalid = 1'b0;

		// reads, including acknowledge side effects
		if (ar_hs) begin
			next_rvalid = 1'b1;
			next_rdata = 32'h0;
			next_rresp = RESP_OKAY;
			lvl = rofs[4:2];
			if (rblk[3:1] == 3'h0) begin
				if (rofs == OFS_PENDING) next_rdata = pending[rc];
				else if (rofs == OFS_MASK) next_rdata = mask[rc];
				else if (rofs == OFS_FORCE) next_rdata = force_low_reg[rc];
				else if (rofs == OFS_SWACK) begin
					next_rdata = {24'h0, sw_vec[rc]};
					if (!sw_hit[rc]) spur_set = 1'b1;
				end else if (rofs == OFS_FLAGS) begin
					if (!rc) begin
						next_rdata = {29'h0, can_flag};
						next_can_armed = can_armed | can_flag;
					end
				end else if (rofs[7:5] == OFS_ACK_HI && lvl != 3'h0) begin
					next_rdata = {24'h0, lvl_vec[rc][lvl]};
					if (!lvl_hit[rc][lvl]) spur_set = 1'b1;
					if (!rc && lvl_hit[rc][lvl] && lvl_vec[rc][lvl] == wdog_vec)
						next_wdog_pend = 1'b0;
				end else if (rofs >= OFS_SLOT0 && rofs < OFS_SLOTEND) begin
					slot_idx = 5'(rofs[7:2] - OFS_SLOT0[7:2]);
					next_rdata = {26'h0, source_level_priority_reg[rc][slot_idx]};
				end else next_rresp = RESP_SLVERR;
			end else if (rblk == BLK_GLOBAL) begin
				// offset zero would be a software ack here and does not exist
				if (rofs[7:5] == 3'h0 && lvl != 3'h0 && rofs[1:0] == 2'h0) begin
					next_rdata = {24'h0, g_vec[lvl]};
					if (!g_hit[lvl]) spur_set = 1'b1;
					if (g_hit[lvl] && g_vec[lvl] == wdog_vec) next_wdog_pend = 1'b0;
				end else next_rresp = RESP_SLVERR;
			end else if (rblk == BLK_IRQ) begin
				if (rofs == OFS_STATUS) next_rdata = 32'(status);
				else if (rofs == OFS_ENABLE) next_rdata = 32'(enable);
				else if (rofs != OFS_CLEAR) next_rresp = RESP_SLVERR;
			end else next_rresp = RESP_SLVERR;
			if (next_rresp == RESP_SLVERR) next_rdata = 32'h0;
		end

		// writes, performed once both halves are held
		if (do_wr) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = RESP_OKAY;
			if (wblk[3:1] == 3'h0) begin
				if (wofs == OFS_MASK) begin
					for (int b = 0; b < 4; b++)
						if (w_strb[b]) next_mask[wc][b*8 +: 8] = w_data[b*8 +: 8];
				end else if (wofs == OFS_FORCE) begin
					for (int b = 0; b < 4; b++)
						if (w_strb[b]) next_force_low_reg[wc][b*8 +: 8] = w_data[b*8 +: 8];
				end else if (wofs == OFS_FLAGS) begin
					// a one clears only a flag already seen as one
					if (!wc && w_strb[0]) begin
						for (int i = 0; i < CAN_COUNT; i++) begin
							if (w_data[i] && can_armed[i]) begin
								next_can_flag[i] = can_s2[i];
								next_can_armed[i] = 1'b0;
							end
						end
					end
				end else if (wofs >= OFS_SLOT0 && wofs < OFS_SLOTEND) begin
					if (w_strb[0])
						next_source_level_priority_reg[wc][5'(wofs[7:2] - OFS_SLOT0[7:2])]
							= w_data[5:0];
				end else if (!(wofs == OFS_PENDING || wofs == OFS_SWACK ||
				               (wofs[7:5] == OFS_ACK_HI && wofs[4:2] != 3'h0)))
					next_bresp = RESP_SLVERR;
			end else if (wblk == BLK_IRQ) begin
				if (wofs == OFS_ENABLE && w_strb[0])
					next_enable = w_data[NUM_EVT-1:0];
				else if (wofs == OFS_CLEAR && w_strb[0])
					next_status = next_status & ~w_data[NUM_EVT-1:0];
				else if (wofs != OFS_STATUS) next_bresp = RESP_SLVERR;
			end else next_bresp = RESP_SLVERR;
		end

		// events set last so that a same-cycle clear loses
		next_status[ST_SPUR] = next_status[ST_SPUR] | spur_set;
		if (wd_s2 && !wd_s3) begin
			next_wdog_pend = 1'b1;
			next_status[ST_WDOG] = 1'b1;
		end
		next_awready = !next_aw_held;
		next_wready = !next_w_held;
		next_arready = !next_rvalid;
		next_ipl = top_lvl;
		next_irq = |(next_status & next_enable);
	end

	// ==================================================
	// registers
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			for (int c = 0; c < NUM_CTRL; c++) begin
				mask[c] <= MASK_RESET;
				force_low_reg[c] <= FORCE_RESET;
				for (int s = 0; s < NUM_SRC; s++)
					source_level_priority_reg[c][s] <= SLOT_RESET;
			end
			can_flag <= '0;
			can_armed <= '0;
			wdog_pend <= 1'b0;
			status <= '0;
			enable <= '0;
			aw_held <= 1'b0;
			aw_addr <= '0;
			w_held <= 1'b0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			s_axi_awready_o <= 1'b0;
			s_axi_wready_o <= 1'b0;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= RESP_OKAY;
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h0;
			s_axi_rresp_o <= RESP_OKAY;
			ipl_o <= 3'h0;
			irq_o <= 1'b0;
		end else begin
			mask <= next_mask;
			force_low_reg <= next_force_low_reg;
			source_level_priority_reg <= next_source_level_priority_reg;
			can_flag <= next_can_flag;
			can_armed <= next_can_armed;
			wdog_pend <= next_wdog_pend;
			status <= next_status;
			enable <= next_enable;
			aw_held <= next_aw_held;
			aw_addr <= next_aw_addr;
			w_held <= next_w_held;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			s_axi_awready_o <= next_awready;
			s_axi_wready_o <= next_wready;
			s_axi_bvalid_o <= next_bvalid;
			s_axi_bresp_o <= next_bresp;
			s_axi_arready_o <= next_arready;
			s_axi_rvalid_o <= next_rvalid;
			s_axi_rdata_o <= next_rdata;
			s_axi_rresp_o <= next_rresp;
			ipl_o <= next_ipl;
			irq_o <= next_irq;
		end
	end
endmodule

`default_nettype wire

//--- design/intc_pkg.sv
// constants shared by the interrupt acknowledge and flag logic
// assumes a 32-bit axi4-lite register bus with 12-bit byte addresses
package intc_pkg;
	// ==================================================
	// structure
	localparam int NUM_CTRL = 2;
	localparam int NUM_SRC  = 32;
	localparam int ADDR_W   = 12;
	localparam int NUM_REQ  = NUM_CTRL * NUM_SRC;
	// ==================================================
	// address map, byte addresses
	localparam logic [3:0] BLK_GLOBAL  = 4'h2;
	localparam logic [3:0] BLK_IRQ     = 4'h3;
	localparam logic [7:0] OFS_PENDING = 8'h00;
	localparam logic [7:0] OFS_MASK    = 8'h04;
	localparam logic [7:0] OFS_FORCE   = 8'h08;
	localparam logic [7:0] OFS_SWACK   = 8'h0c;
	localparam logic [7:0] OFS_FLAGS   = 8'h10;
	localparam logic [7:0] OFS_SLOT0   = 8'h40;
	localparam logic [7:0] OFS_SLOTEND = 8'hc0;
	localparam logic [2:0] OFS_ACK_HI  = 3'b001;
	localparam logic [7:0] OFS_STATUS  = 8'h00;
	localparam logic [7:0] OFS_ENABLE  = 8'h04;
	localparam logic [7:0] OFS_CLEAR   = 8'h08;
	// ==================================================
	// reset values
	localparam logic [31:0] MASK_RESET  = 32'hffffffff;
	localparam logic [31:0] FORCE_RESET = 32'h00000000;
	localparam logic [5:0]  SLOT_RESET  = 6'h00;
	// ==================================================
	// sources and vectors
	localparam int WDOG_SRC  = 8;
	localparam int CAN_FIRST = 24;
	localparam int CAN_COUNT = 3;
	localparam int VEC_BASE  = 64;
	localparam logic [7:0] SPURIOUS_VEC = 8'h18;
	localparam int ST_WDOG   = 0;
	localparam int ST_SPUR   = 1;
	localparam int NUM_EVT   = 2;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- test/intc_ack_checker.sv
// port checks for the interrupt acknowledge block
// assumes a bind from the bench top; one clock domain
`timescale 1ns/1ps
`default_nettype none
module intc_ack_checker (
	input wire logic	clk_i,
	input wire logic	rst_n_i,
	input wire logic	s_axi_awvalid_i,
	input wire logic	s_axi_awready_o,
	input wire logic	s_axi_wvalid_i,
	input wire logic	s_axi_wready_o,
	input wire logic [1:0]	s_axi_bresp_o,
	input wire logic	s_axi_bvalid_o,
	input wire logic	s_axi_bready_i,
	input wire logic [intc_pkg::ADDR_W-1:0]	s_axi_araddr_i,
	input wire logic	s_axi_arvalid_i,
	input wire logic	s_axi_arready_o,
	input wire logic [31:0]	s_axi_rdata_o,
	input wire logic [1:0]	s_axi_rresp_o,
	input wire logic	s_axi_rvalid_o,
	input wire logic	s_axi_rready_i,
	input wire logic [2:0]	ipl_o
);
	import intc_pkg::*;
	// ==========
	// handshakes taken at this edge
	wire logic ar_take = s_axi_arvalid_i && s_axi_arready_o;
	wire logic wr_take = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// ==========
	// bus answers
	property p_rlat; ar_take |=> s_axi_rvalid_o; endproperty
	a_rlat: assert property (p_rlat) else $error("read answer late");
	property p_rhold; s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o); endproperty
	a_rhold: assert property (p_rhold) else $error("read data dropped");
	property p_arblk; s_axi_rvalid_o |-> !s_axi_arready_o; endproperty
	a_arblk: assert property (p_arblk) else $error("second read taken");
	property p_bhold; s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o); endproperty
	a_bhold: assert property (p_bhold) else $error("write answer dropped");
	property p_wlat; wr_take |-> ##[1:3] s_axi_bvalid_o; endproperty
	a_wlat: assert property (p_wlat) else $error("write answer late");
	// no software ack in global space; level acks answer there
	property p_glob; ar_take && s_axi_araddr_i == 12'h200 |=> s_axi_rresp_o == RESP_SLVERR && s_axi_rdata_o == 32'h0; endproperty
	a_glob: assert property (p_glob) else $error("global soft ack exists");
	property p_glok; ar_take && s_axi_araddr_i[11:5] == 7'h10 && s_axi_araddr_i[4:2] != 3'h0 |=> s_axi_rresp_o == RESP_OKAY; endproperty
	a_glok: assert property (p_glok) else $error("global level ack refused");
	// sources parked disabled, so no level right after reset
	property p_quiet; $rose(rst_n_i) |-> (ipl_o == 3'h0)[*8]; endproperty
	a_quiet: assert property (p_quiet) else $error("level raised after reset");
endmodule
`default_nettype wire

//--- test/cpu_bus_model.sv
// bus master standing in for the processor core, one access at a time
// assumes the block's axi4-lite slave on the same clock
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
	input wire logic	clk_i,
	output var logic [11:0]	awaddr_o,
	output var logic	awvalid_o,
	input wire logic	awready_i,
	output var logic [31:0]	wdata_o,
	output var logic	wvalid_o,
	input wire logic	wready_i,
	input wire logic [1:0]	bresp_i,
	input wire logic	bvalid_i,
	output var logic	bready_o,
	output var logic [11:0]	araddr_o,
	output var logic	arvalid_o,
	input wire logic	arready_i,
	input wire logic [31:0]	rdata_i,
	input wire logic [1:0]	rresp_i,
	input wire logic	rvalid_i,
	output var logic	rready_o
);
	initial {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o, araddr_o, arvalid_o, rready_o} = '0;
	// released lines flip so a stale value never passes
	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk_i);
		awaddr_o <= a;
		wdata_o <= d;
		awvalid_o <= 1'b1;
		wvalid_o <= 1'b1;
		bready_o <= 1'b1;
		do begin
			@(posedge clk_i);
			if (awready_i && awvalid_o) begin
				awvalid_o <= 1'b0;
				awaddr_o <= ~a;
			end
			if (wready_i && wvalid_o) begin
				wvalid_o <= 1'b0;
				wdata_o <= ~d;
			end
		end while (!bvalid_i);
		r = bresp_i;
		bready_o <= 1'b0;
	endtask
	// acknowledge cycles are plain reads of level-coded addresses
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_i);
		araddr_o <= a;
		arvalid_o <= 1'b1;
		rready_o <= 1'b1;
		do begin
			@(posedge clk_i);
			if (arready_i && arvalid_o) begin
				arvalid_o <= 1'b0;
				araddr_o <= ~a;
			end
		end while (!rvalid_i);
		d = rdata_i;
		r = rresp_i;
		rready_o <= 1'b0;
	endtask
endmodule
`default_nettype wire

//--- test/intc_ack_test.sv
// self-checking bench for the interrupt acknowledge and flag block
// assumes the design package, the bus model and the port checker
`timescale 1ns/1ps
`default_nettype none
module intc_ack_test;
	import intc_pkg::*;
	logic	clk = 1'b0;
	logic	rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
	logic	arvalid, arready, rvalid, rready, irq, wdog;
	logic [11:0]	awaddr, araddr;
	logic [31:0]	wdata, rdata;
	logic [1:0]	bresp, rresp;
	logic [2:0]	ipl, can;
	logic [NUM_REQ-1:0]	req;
	int	bad_count, check_count;
	always #2 clk = ~clk;
	intc_ack intc_ack_i (.clk_i(clk), .rst_n_i(rst_n), .s_axi_awaddr_i(awaddr),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .hw_req_i(req), .wdog_timeout_i(wdog),
		.can_event_i(can), .ipl_o(ipl), .irq_o(irq));
	cpu_bus_model cpu_bus_model_i (.clk_i(clk), .awaddr_o(awaddr), .awvalid_o(awvalid),
		.awready_i(awready), .wdata_o(wdata), .wvalid_o(wvalid), .wready_i(wready),
		.bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr),
		.arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata), .rresp_i(rresp),
		.rvalid_i(rvalid), .rready_o(rready));
	// ==========
	// shared checks and bus wrappers
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e = RESP_OKAY);
		logic [1:0] r;
		cpu_bus_model_i.wr(a, d, r);
		chk("bresp", 32'(e), 32'(r));
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
		logic [31:0] d;
		logic [1:0] r;
		cpu_bus_model_i.rd(a, d, r);
		chk("rresp", 32'(er), 32'(r));
		chk($sformatf("rdata %h", a), e, d);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic pins(input logic [2:0] l, input logic i);
		chk("ipl", 32'(l), 32'(ipl));
		chk("irq", 32'(i), 32'(irq));
	endtask
	// ==========
	// scenarios
	task automatic t_reset();
		rc(12'h040, 32'h0);
		rc(12'h060, 32'h0);
		rc(12'h004, MASK_RESET);
		rc(12'h008, FORCE_RESET);
		rc(12'hf00, 32'h0, RESP_SLVERR);
		wr(12'hf00, 32'h1, RESP_SLVERR);
		wr(12'h104, 32'h0);
		req <= '1;
		tick(4);
		pins(3'h0, 1'b0);
		rc(12'h10c, 32'(SPURIOUS_VEC));
		wr(12'h104, MASK_RESET);
		req <= '0;
	endtask
	task automatic t_force();
		wr(12'h044, 32'h1a); // source 1 level 3 prio 2
		wr(12'h054, 32'h1e); // source 5 level 3 prio 6
		wr(12'h004, ~32'h22);
		wr(12'h008, 32'h22);
		rc(12'h008, 32'h22);
		tick(4);
		pins(3'h3, 1'b0);
		rc(12'h000, 32'h22);
		rc(12'h00c, 32'd69);
		rc(12'h02c, 32'd69);
		wr(12'h008, 32'h2);
		rc(12'h00c, 32'd65);
		wr(12'h008, 32'h0);
		rc(12'h00c, 32'(SPURIOUS_VEC));
	endtask
	task automatic t_global();
		wr(12'h048, 32'h25); // level 4 prio 5
		wr(12'h14c, 32'h21); // level 4 prio 1
		wr(12'h004, ~32'h4);
		wr(12'h104, ~32'h8);
		req <= 64'h0000_0008_0000_0004;
		tick(4);
		rc(12'h210, 32'd66);
		rc(12'h10c, 32'd99);
		wr(12'h14c, 32'h27);
		rc(12'h210, 32'd99);
		rc(12'h00c, 32'd66);
		rc(12'h200, 32'h0, RESP_SLVERR);
		req <= '0;
	endtask
	// watchdog request, status, enable and clear
	task automatic t_wdog();
		wr(12'h060, 32'h33); // level 6 prio 3
		wr(12'h004, ~32'h100);
		wr(12'h308, 32'h3);
		wr(12'h304, 32'h1);
		wdog <= 1'b1;
		tick(3);
		wdog <= 1'b0;
		tick(4);
		pins(3'h6, 1'b1);
		rc(12'h300, 32'h1);
		rc(12'h060, 32'h33); // settings survive, so no reset
		rc(12'h038, 32'd72);
		rc(12'h038, 32'(SPURIOUS_VEC));
		rc(12'h300, 32'h3);
		wr(12'h308, 32'h1);
		tick(2);
		pins(3'h0, 1'b0);
		wr(12'h304, 32'h2);
		tick(2);
		pins(3'h0, 1'b1);
		wr(12'h308, 32'h2);
		rc(12'h308, 32'h0);
		tick(2);
		pins(3'h0, 1'b0);
	endtask
	task automatic t_can();
		can <= 3'h7;
		tick(4);
		can <= 3'h0;
		tick(4);
		wr(12'h010, 32'h7); // unread flags stay
		rc(12'h010, 32'h7);
		wr(12'h010, 32'h2);
		rc(12'h010, 32'h5);
		wr(12'h010, 32'h5);
		rc(12'h010, 32'h0);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		{rst_n, wdog, can, req, bad_count, check_count} = '0;
		tick(16);
		rst_n <= 1'b1;
		tick(4);
		t_reset();
		t_force();
		t_global();
		t_wdog();
		t_can();
		final_report();
	end
	// run needs a few hundred cycles; cut a hang well beyond
	initial begin
		#80000;
		bad_count++;
		final_report();
	end
endmodule
bind intc_ack intc_ack_checker intc_ack_checker_i (.clk_i, .rst_n_i, .s_axi_awvalid_i,
	.s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
	.s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
	.s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .ipl_o);
`default_nettype wire
